// File: hdl/strap_pkg.sv
// Function
// R01 - each gpio pin is input-only or bidirectional by its own output-enable register bit
// R02 - gpio 7 strap high selects 16-bit eeprom words, low selects 8-bit
// R03 - gpio 6:5 latched at init as receive termination adjust, default 00
// R04 - gpio 4:3 latched at init as transmit termination adjust, default 00
// R05 - gpio 2:0 latched at init as equalization bits 3:1, default 100
// R06 - uart1 select bit 3 latched at init as equalization bit 0, default 0
// R07 - uart1 select bits 2:0 latched at init as drive current bits 3:1, default 000
// R08 - uart0 select bit 3 latched at init as drive current bit 0, default 0
// R09 - uart0 select bit 2 latched at init as low-drive flag, default 0
// R10 - uart0 select bit 0 latched at init as high-drive flag, default 0
// R11 - board keeps uart0 select bit 1 low at init; sampled as phy debug strap
// R12 - after init a four-bit bus selects the uart0 transceiver mode
// R13 - after init a second four-bit bus selects the uart1 transceiver mode
// R14 - in the L2 link state a ring on uart0 asserts the low wake output
// R15 - ring indicator inputs are active low; a low level signals ring
// R16 - straps captured once after reset release and held until next reset
// R17 - transceiver mode pin codes come from a software configuration register
// R18 - gpio pins leave reset as inputs so strap resistors set their levels
package strap_pkg;

   localparam int unsigned CLK_HZ        = 20_000_000;
   // pins must sit stable this long after reset release before they are latched
   localparam int unsigned SETTLE_NS     = 400;
   localparam int unsigned SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned SETTLE_W      = 4;

   localparam logic [7:0]  REG_GPIO_OE   = 8'h00;
   localparam logic [7:0]  REG_GPIO_OUT  = 8'h04;
   localparam logic [7:0]  REG_GPIO_IN   = 8'h08;
   localparam logic [7:0]  REG_XCVR_MODE = 8'h0c;
   localparam logic [7:0]  REG_STRAPS    = 8'h10;
   localparam logic [7:0]  REG_IRQ_STAT  = 8'h14;
   localparam logic [7:0]  REG_IRQ_CLR   = 8'h18;
   localparam logic [7:0]  REG_IRQ_EN    = 8'h1c;

   localparam int unsigned GPIO_W        = 8;
   localparam int unsigned SEL_W         = 4;
   localparam int unsigned EE_ORG_BIT    = 7;
   localparam int unsigned RXT_HI        = 6;
   localparam int unsigned RXT_LO        = 5;
   localparam int unsigned TXT_HI        = 4;
   localparam int unsigned TXT_LO        = 3;
   localparam int unsigned DEQ_HI        = 2;
   localparam int unsigned SEL_DEQ0_BIT  = 3;
   localparam int unsigned SEL_DTX0_BIT  = 3;
   localparam int unsigned SEL_LO_BIT    = 2;
   localparam int unsigned SEL_DBG_BIT   = 1;
   localparam int unsigned SEL_HI_BIT    = 0;
   localparam int unsigned XCVR1_LO      = 4;
   localparam int unsigned STRAP_VALID_BIT = 16;

   localparam int unsigned IRQ_W         = 3;
   localparam int unsigned IRQ_RING0     = 0;
   localparam int unsigned IRQ_RING1     = 1;
   localparam int unsigned IRQ_WAKE      = 2;

   // suggested pin codes; software may load any pattern
   localparam logic [3:0]  XCVR_CODE_RS232   = 4'h0;
   localparam logic [3:0]  XCVR_CODE_RS422   = 4'h1;
   localparam logic [3:0]  XCVR_CODE_RS485_4 = 4'h2;
   localparam logic [3:0]  XCVR_CODE_RS485_2 = 4'h3;
   localparam logic [7:0]  XCVR_MODE_RESET   = {XCVR_CODE_RS232, XCVR_CODE_RS232};
   localparam logic [7:0]  GPIO_OE_RESET     = 8'h00;
   localparam logic [7:0]  GPIO_OUT_RESET    = 8'h00;
   localparam logic [1:0]  RING_IDLE         = 2'h3;

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'h0;

   typedef struct packed {
      logic [3:0] lane_drive_current_strap;
      logic [3:0] lane_equalization_strap;
      logic       low_drive_strap;
      logic       high_drive_strap;
      logic       phy_debug_strap;
      logic       eeprom_word_width_strap;
      logic [1:0] rx_termination_strap;
      logic [1:0] tx_termination_strap;
   } strap_t;

   localparam strap_t STRAP_DEFAULT = '{
      lane_drive_current_strap: 4'h0,
      lane_equalization_strap:  4'h8,
      low_drive_strap:          1'h0,
      high_drive_strap:         1'h0,
      phy_debug_strap:          1'h0,
      eeprom_word_width_strap:  1'h0,
      rx_termination_strap:     2'h0,
      tx_termination_strap:     2'h0
   };

   typedef enum logic [1:0] {
      ST_HOLD   = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN    = 2'b10
   } init_state_t;

endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync_out
);

   logic [W-1:0] meta_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff      <= RST_VAL;
         pin_sync_out <= RST_VAL;
      end else begin
         meta_ff      <= pin_in;
         pin_sync_out <= meta_ff;
      end
   end

endmodule
`default_nettype wire

// File: hdl/irq_sticky.sv
`timescale 1ns/10ps
`default_nettype none
module irq_sticky #(
   parameter int unsigned W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] set_evt,
   input  wire logic [W-1:0] clr_req,
   input  wire logic [W-1:0] enable,
   output logic      [W-1:0] status_ff,
   output logic              irq_ff
);

   logic [W-1:0] nxt_status;

   // set beats a clear landing in the same cycle
   assign nxt_status = (status_ff & ~clr_req) | set_evt;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= '0;
         irq_ff    <= 1'b0;
      end else begin
         status_ff <= nxt_status;
         irq_ff    <= |(nxt_status & enable);
      end
   end

endmodule
`default_nettype wire

// File: hdl/strap_gpio_wake_pins.sv
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module strap_gpio_wake_pins (
   input  wire logic                       core_clk,
   input  wire logic                       rstn,
   // ahb-lite slave
   input  wire logic                       hsel,
   input  wire logic [31:0]                haddr,
   input  wire logic [1:0]                 htrans,
   input  wire logic                       hwrite,
   input  wire logic [2:0]                 hsize,
   input  wire logic [31:0]                hwdata,
   input  wire logic                       hready,
   output logic                            hreadyout,
   output logic                            hresp,
   output logic [31:0]                     hrdata,
   output logic                            irq,
   // link power state from the pcie core, same clock
   input  wire logic                       link_in_l2,
   // pins
   input  wire logic [1:0]                 ring_indicator_n,
   output logic                            wake_n,
   input  wire logic [strap_pkg::GPIO_W-1:0] gpio_i,
   output logic [strap_pkg::GPIO_W-1:0]    gpio_o,
   output logic [strap_pkg::GPIO_W-1:0]    gpio_oe,
   input  wire logic [strap_pkg::SEL_W-1:0] uart0_xcvr_mode_sel_i,
   output logic [strap_pkg::SEL_W-1:0]     uart0_xcvr_mode_sel_o,
   output logic [strap_pkg::SEL_W-1:0]     uart0_xcvr_mode_sel_oe,
   input  wire logic [strap_pkg::SEL_W-1:0] uart1_xcvr_mode_sel_i,
   output logic [strap_pkg::SEL_W-1:0]     uart1_xcvr_mode_sel_o,
   output logic [strap_pkg::SEL_W-1:0]     uart1_xcvr_mode_sel_oe,
   output strap_pkg::strap_t               straps,
   output logic                            straps_valid
);
   import strap_pkg::*;

   // register map: byte offsets, one word each, data in the low bits;
   // unmapped offsets read zero and ignore writes, every response is okay
   //   0x00 gpio output enable, rw, bit set = pin driven once straps latched
   //   0x04 gpio drive value, rw, reaches the pin one cycle after the write
   //   0x08 gpio pin levels, ro, taken through the two-flop synchroniser
   //   0x0c transceiver mode, rw, [3:0] uart0 select pins, [7:4] uart1 pins
   //   0x10 latched straps, ro, [15:0] strap word, [16] latch done
   //   0x14 event status, ro, sticky: [0] ring0 fall, [1] ring1 fall, [2] wake
   //   0x18 event clear, wo, one clears; an event in the same cycle wins
   //   0x1c event enable, rw, same layout as status
   //
   // transceiver mode codes: select pins carry the nibble as written,
   // no decode in here, so board wiring picks the meaning; suggested codes
   //   0 rs-232, 1 rs-422, 2 rs-485 four-wire, 3 rs-485 two-wire
   // reset leaves both nibbles at the rs-232 code, so a transceiver wired
   // straight to these pins comes up in the most forgiving mode
   //
   // strap word, msb first:
   //   [15:12] lane drive current = {uart1 sel[2:0], uart0 sel[3]}
   //   [11:8]  lane equalization  = {gpio[2:0], uart1 sel[3]}
   //   [7]     low drive          = uart0 sel[2]
   //   [6]     high drive         = uart0 sel[0]
   //   [5]     phy debug          = uart0 sel[1], board keeps it low
   //   [4]     eeprom word width  = gpio[7], high for 16-bit words
   //   [3:2]   rx termination     = gpio[6:5]
   //   [1:0]   tx termination     = gpio[4:3]
   //
   // straps sampled after the settle count, not at the reset edge, so
   // strap resistors have time to win over floating pins; the price is
   // that pin driver writes stay off the pins until the latch is done

   logic                rst_meta_ff;
   logic                rst_sync_ff;
   logic [GPIO_W-1:0]   gpio_sync;
   logic [SEL_W-1:0]    sel0_sync;
   logic [SEL_W-1:0]    sel1_sync;
   logic [1:0]          ring_n_sync;
   logic [1:0]          ring_act_prev_ff;
   logic [1:0]          ring_act;
   init_state_t         state_ff;
   logic [SETTLE_W-1:0] settle_cnt_ff;
   logic                capture;
   logic [GPIO_W-1:0]   gpio_oe_reg_ff;
   logic [GPIO_W-1:0]   gpio_out_reg_ff;
   logic [7:0]          xcvr_mode_ff;
   logic [IRQ_W-1:0]    irq_en_ff;
   logic [IRQ_W-1:0]    irq_status;
   logic [IRQ_W-1:0]    irq_set;
   logic [IRQ_W-1:0]    irq_clr;
   logic                wake_fire;
   logic                accept;
   logic                wr_pend_ff;
   logic                rd_pend_ff;
   logic [7:0]          wr_addr_ff;
   logic [7:0]          rd_addr_ff;
   logic                wr_go;
   logic [31:0]         rd_mux;

   // reset: asynchronous assert, two-flop release
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   pin_sync #(.W(GPIO_W), .RST_VAL(GPIO_OUT_RESET)) u_sync_gpio (
      .core_clk     (core_clk),
      .rst_n        (rst_sync_ff),
      .pin_in       (gpio_i),
      .pin_sync_out (gpio_sync)
   );

   pin_sync #(.W(2 * SEL_W), .RST_VAL(XCVR_MODE_RESET)) u_sync_sel (
      .core_clk     (core_clk),
      .rst_n        (rst_sync_ff),
      .pin_in       ({uart1_xcvr_mode_sel_i, uart0_xcvr_mode_sel_i}),
      .pin_sync_out ({sel1_sync, sel0_sync})
   );

   pin_sync #(.W(2), .RST_VAL(RING_IDLE)) u_sync_ring (
      .core_clk     (core_clk),
      .rst_n        (rst_sync_ff),
      .pin_in       (ring_indicator_n),
      .pin_sync_out (ring_n_sync)
   );

   // init sequence: pins undriven until straps are latched
   assign capture = (state_ff == ST_SETTLE) && (settle_cnt_ff == SETTLE_W'(SETTLE_CYC - 1));

   always_ff @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         state_ff      <= ST_HOLD;
         settle_cnt_ff <= '0;
      end else begin
         case (state_ff)
            ST_HOLD: begin
               state_ff      <= ST_SETTLE;
               settle_cnt_ff <= '0;
            end
            ST_SETTLE: begin
               settle_cnt_ff <= settle_cnt_ff + SETTLE_W'(1);
               if (capture) begin
                  state_ff <= ST_RUN;
               end
            end
            ST_RUN: begin
               state_ff <= ST_RUN;
            end
            default: begin
               state_ff <= ST_HOLD;
            end
         endcase
      end
   end

   // strap latch, taken once per reset
   always_ff @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         straps       <= STRAP_DEFAULT;
         straps_valid <= 1'b0;
      end else if (capture) begin // R16
         straps_valid                           <= 1'b1;
         straps.eeprom_word_width_strap         <= gpio_sync[EE_ORG_BIT]; // R02
         straps.rx_termination_strap            <= gpio_sync[RXT_HI:RXT_LO]; // R03
         straps.tx_termination_strap            <= gpio_sync[TXT_HI:TXT_LO]; // R04
         straps.lane_equalization_strap         <= {gpio_sync[DEQ_HI:0], sel1_sync[SEL_DEQ0_BIT]}; // R05 R06
         straps.lane_drive_current_strap        <= {sel1_sync[2:0], sel0_sync[SEL_DTX0_BIT]}; // R07 R08
         straps.low_drive_strap                 <= sel0_sync[SEL_LO_BIT]; // R09
         straps.phy_debug_strap                 <= sel0_sync[SEL_DBG_BIT]; // R11
         straps.high_drive_strap                <= sel0_sync[SEL_HI_BIT]; // R10
      end
   end

   // ahb-lite: writes zero-wait, reads take one wait state so a
   // write in the preceding data phase is always seen
   assign accept = hsel && hready && (htrans[1] == HTRANS_NONSEQ[1]);
   assign wr_go  = wr_pend_ff && hready;

   always_ff @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         wr_addr_ff <= '0;
         rd_addr_ff <= '0;
         hreadyout  <= 1'b1;
         hresp      <= HRESP_OKAY;
         hrdata     <= '0;
      end else begin
         rd_pend_ff <= accept && !hwrite;
         hreadyout  <= !(accept && !hwrite);
         hresp      <= HRESP_OKAY;
         if (hready) begin
            wr_pend_ff <= accept && hwrite;
         end
         if (accept) begin
            wr_addr_ff <= haddr[7:0];
            rd_addr_ff <= haddr[7:0];
         end
         if (rd_pend_ff) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_comb begin
      rd_mux = '0;
      if (rd_addr_ff == REG_GPIO_OE) begin
         rd_mux[GPIO_W-1:0] = gpio_oe_reg_ff;
      end else if (rd_addr_ff == REG_GPIO_OUT) begin
         rd_mux[GPIO_W-1:0] = gpio_out_reg_ff;
      end else if (rd_addr_ff == REG_GPIO_IN) begin
         rd_mux[GPIO_W-1:0] = gpio_sync;
      end else if (rd_addr_ff == REG_XCVR_MODE) begin
         rd_mux[7:0] = xcvr_mode_ff;
      end else if (rd_addr_ff == REG_STRAPS) begin
         rd_mux[15:0]            = straps;
         rd_mux[STRAP_VALID_BIT] = straps_valid;
      end else if (rd_addr_ff == REG_IRQ_STAT) begin
         rd_mux[IRQ_W-1:0] = irq_status;
      end else if (rd_addr_ff == REG_IRQ_EN) begin
         rd_mux[IRQ_W-1:0] = irq_en_ff;
      end else begin
         rd_mux = '0;
      end
   end

   // software registers; oe resets to inputs so straps can be read
   always_ff @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         gpio_oe_reg_ff  <= GPIO_OE_RESET; // R18
         gpio_out_reg_ff <= GPIO_OUT_RESET;
         xcvr_mode_ff    <= XCVR_MODE_RESET;
         irq_en_ff       <= '0;
      end else if (wr_go) begin
         if (wr_addr_ff == REG_GPIO_OE) begin
            gpio_oe_reg_ff <= hwdata[GPIO_W-1:0]; // R01
         end else if (wr_addr_ff == REG_GPIO_OUT) begin
            gpio_out_reg_ff <= hwdata[GPIO_W-1:0];
         end else if (wr_addr_ff == REG_XCVR_MODE) begin
            xcvr_mode_ff <= hwdata[7:0]; // R17
         end else if (wr_addr_ff == REG_IRQ_EN) begin
            irq_en_ff <= hwdata[IRQ_W-1:0];
         end
      end
   end

   assign irq_clr = (wr_go && (wr_addr_ff == REG_IRQ_CLR)) ? hwdata[IRQ_W-1:0] : '0;

   // pin drivers held off until the straps are latched
   always_ff @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         gpio_oe                <= '0;
         gpio_o                 <= '0;
         uart0_xcvr_mode_sel_oe <= '0;
         uart1_xcvr_mode_sel_oe <= '0;
         uart0_xcvr_mode_sel_o  <= '0;
         uart1_xcvr_mode_sel_o  <= '0;
      end else begin
         gpio_oe <= straps_valid ? gpio_oe_reg_ff : '0; // R01 R18
         gpio_o  <= gpio_out_reg_ff;
         uart0_xcvr_mode_sel_oe <= {SEL_W{straps_valid}}; // R12
         uart1_xcvr_mode_sel_oe <= {SEL_W{straps_valid}}; // R13
         uart0_xcvr_mode_sel_o  <= xcvr_mode_ff[SEL_W-1:0]; // R12
         uart1_xcvr_mode_sel_o  <= xcvr_mode_ff[XCVR1_LO +: SEL_W]; // R13
      end
   end

   // ring is a low level on the pin
   assign ring_act  = ~ring_n_sync; // R15
   assign wake_fire = straps_valid && link_in_l2 && ring_act[0] && wake_n;

   // wake stays asserted until the link leaves L2
   always_ff @(posedge core_clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         wake_n           <= 1'b1;
         ring_act_prev_ff <= '0;
      end else begin
         ring_act_prev_ff <= ring_act;
         if (wake_fire) begin
            wake_n <= 1'b0; // R14
         end else if (!link_in_l2) begin
            wake_n <= 1'b1;
         end
      end
   end

   always_comb begin
      irq_set            = '0;
      irq_set[IRQ_RING0] = ring_act[0] && !ring_act_prev_ff[0];
      irq_set[IRQ_RING1] = ring_act[1] && !ring_act_prev_ff[1];
      irq_set[IRQ_WAKE]  = wake_fire;
   end

   irq_sticky #(.W(IRQ_W)) u_irq (
      .core_clk  (core_clk),
      .rst_n     (rst_sync_ff),
      .set_evt   (irq_set),
      .clr_req   (irq_clr),
      .enable    (irq_en_ff),
      .status_ff (irq_status),
      .irq_ff    (irq)
   );

endmodule
`default_nettype wire

// File: tb/strap_gpio_wake_pins_sva.sv
`timescale 1ns/10ps
`default_nettype none
module strap_gpio_wake_pins_sva
   import strap_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rstn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       link_in_l2,
   input wire logic [1:0] ring_indicator_n,
   input wire logic       wake_n,
   input wire logic [7:0] gpio_oe,
   input wire logic [3:0] uart0_xcvr_mode_sel_oe,
   input wire logic [3:0] uart1_xcvr_mode_sel_oe,
   input wire strap_t     straps,
   input wire logic       straps_valid
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence rd_taken;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   sequence wr_taken;
      hsel && hready && htrans[1] && hwrite;
   endsequence
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   AST_READ_WAIT: assert property (rd_taken |=> one_wait)
      else $error("read wait state wrong");
   AST_WRITE_NOWAIT: assert property (wr_taken |=> hreadyout)
      else $error("write stalled");
   AST_PINS_UNDRIVEN: assert property (!straps_valid |-> (gpio_oe | uart0_xcvr_mode_sel_oe | uart1_xcvr_mode_sel_oe) == 8'h00)
      else $error("pin driven before straps latched");
   AST_SEL_OE_ON: assert property ($rose(straps_valid) |=> &{uart0_xcvr_mode_sel_oe, uart1_xcvr_mode_sel_oe})
      else $error("select pins not driven after init");
   AST_STRAP_DEFAULT: assert property (!straps_valid |-> straps == 16'h0800)
      else $error("strap value not default before latch");
   AST_STRAPS_HOLD: assert property ($past(straps_valid) && straps_valid |-> $stable(straps))
      else $error("straps changed after latch");
   AST_WAKE_CAUSE: assert property ($fell(wake_n) |-> $past(link_in_l2) && $past(straps_valid) && !$past(ring_indicator_n[0], 3))
      else $error("wake without ring in low power state");
   AST_WAKE_HOLD: assert property (!wake_n && link_in_l2 |=> !wake_n)
      else $error("wake dropped in low power state");
   AST_WAKE_RELEASE: assert property (!wake_n && !link_in_l2 |=> wake_n)
      else $error("wake held after link exit");
endmodule
bind strap_gpio_wake_pins strap_gpio_wake_pins_sva u_sva (.core_clk, .rstn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .link_in_l2, .ring_indicator_n, .wake_n, .gpio_oe, .uart0_xcvr_mode_sel_oe,
   .uart1_xcvr_mode_sel_oe, .straps, .straps_valid);
`default_nettype wire

// File: tb/board_pins_model.sv
`timescale 1ns/10ps
`default_nettype none
module board_pins_model (
   input wire logic [7:0] gpio_o,
   input wire logic [7:0] gpio_oe,
   input wire logic [3:0] sel0_o,
   input wire logic [3:0] sel0_oe,
   input wire logic [3:0] sel1_o,
   input wire logic [3:0] sel1_oe,
   input wire logic [7:0] board_gpio,
   input wire logic [3:0] board_sel0,
   input wire logic [3:0] board_sel1,
   input wire logic [1:0] ring_req,
   output logic     [7:0] gpio_i,
   output logic     [3:0] sel0_i,
   output logic     [3:0] sel1_i,
   output logic     [1:0] ring_indicator_n
);
   // undriven pins settle to the board resistor level
   assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & board_gpio);
   // debug strap resistor is never fitted
   assign sel0_i = (sel0_oe & sel0_o) | (~sel0_oe & board_sel0 & 4'hd);
   assign sel1_i = (sel1_oe & sel1_o) | (~sel1_oe & board_sel1);
   assign ring_indicator_n = ~ring_req;
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; $display("mismatch %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
   import strap_pkg::*;
   logic        core_clk, rstn, hsel, hwrite, link_in_l2, hreadyout, hresp, irq, wake_n, straps_valid;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, ring_req, ring_indicator_n;
   logic [2:0]  hsize;
   logic [7:0]  gpio_i, gpio_o, gpio_oe, board_gpio;
   logic [3:0]  sel0_i, sel0_o, sel0_oe, sel1_i, sel1_o, sel1_oe, board_sel0, board_sel1;
   strap_t      straps;
   int          miscompares, checks_done, cycles;

   strap_gpio_wake_pins u_strap_gpio_wake_pins (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .link_in_l2, .ring_indicator_n, .wake_n, .gpio_i,
      .gpio_o, .gpio_oe, .uart0_xcvr_mode_sel_i(sel0_i), .uart0_xcvr_mode_sel_o(sel0_o),
      .uart0_xcvr_mode_sel_oe(sel0_oe), .uart1_xcvr_mode_sel_i(sel1_i), .uart1_xcvr_mode_sel_o(sel1_o),
      .uart1_xcvr_mode_sel_oe(sel1_oe), .straps, .straps_valid);
   board_pins_model u_board_pins_model (.gpio_o, .gpio_oe, .sel0_o, .sel0_oe, .sel1_o, .sel1_oe, .board_gpio,
      .board_sel0, .board_sel1, .ring_req, .gpio_i, .sel0_i, .sel1_i, .ring_indicator_n);

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic stop_test();
      if (miscompares == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // run is well under a thousand cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         stop_test();
      end
   end

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask

   task automatic start(input strap_t e);
      rstn <= 1'b0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge core_clk);
      `CHK(gpio_oe, 8'h00)
      for (int i = 0; i < 40 && straps_valid !== 1'b1; i++) @(posedge core_clk);
      `CHK(straps_valid, 1'b1)
      `CHK(straps, e)
   endtask

   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      link_in_l2 = 1'b0;
      ring_req = 2'h0;
      board_gpio = 8'hb5;
      board_sel0 = 4'hf;
      board_sel1 = 4'hb;
      start(16'h7bd6);
      board_gpio <= 8'h3c;
      board_sel1 <= 4'h0;
      repeat (4) @(posedge core_clk);
      `CHK(straps, 16'h7bd6)
      rdc(REG_STRAPS, 32'h17bd6);
      bus(1'b1, REG_GPIO_OE, 32'h0f);
      bus(1'b1, REG_GPIO_OUT, 32'h5a);
      repeat (4) @(posedge core_clk);
      `CHK(gpio_oe, 8'h0f)
      `CHK(gpio_o, 8'h5a)
      rdc(REG_GPIO_IN, 32'h3a);
      rdc(REG_GPIO_OUT, 32'h5a);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, REG_XCVR_MODE, {24'h0, 4'(3 - c), 4'(c)});
         repeat (2) @(posedge core_clk);
         `CHK(sel0_o, 4'(c))
         `CHK(sel1_o, 4'(3 - c))
         `CHK({sel1_oe, sel0_oe}, 8'hff)
         rdc(REG_XCVR_MODE, {24'h0, 4'(3 - c), 4'(c)});
      end
      bus(1'b1, 8'h40, 32'hffff_ffff);
      rdc(8'h40, 32'h0);
      `CHK(hresp, HRESP_OKAY)
      bus(1'b1, REG_IRQ_EN, 32'h7);
      rdc(REG_IRQ_EN, 32'h7);
      link_in_l2 <= 1'b1;
      ring_req <= 2'b10;
      repeat (8) @(posedge core_clk);
      `CHK(wake_n, 1'b1)
      `CHK(irq, 1'b1)
      rdc(REG_IRQ_STAT, 32'h2);
      ring_req <= 2'b00;
      bus(1'b1, REG_IRQ_CLR, 32'h7);
      rdc(REG_IRQ_STAT, 32'h0);
      ring_req <= 2'b01;
      for (int i = 0; i < 10 && wake_n !== 1'b0; i++) @(posedge core_clk);
      `CHK(wake_n, 1'b0)
      rdc(REG_IRQ_STAT, 32'h5);
      bus(1'b1, REG_IRQ_EN, 32'h0);
      repeat (2) @(posedge core_clk);
      `CHK(irq, 1'b0)
      link_in_l2 <= 1'b0;
      ring_req <= 2'b00;
      repeat (3) @(posedge core_clk);
      `CHK(wake_n, 1'b1)
      bus(1'b1, REG_IRQ_CLR, 32'h7);
      rdc(REG_IRQ_STAT, 32'h0);
      // open straps: pull-downs everywhere but gpio 2
      board_gpio <= 8'h04;
      board_sel0 <= 4'h0;
      start(16'h0800);
      rdc(REG_GPIO_OE, 32'h0);
      stop_test();
   end
endmodule
`default_nettype wire
